// file: src/ptinj_device.sv
// Summary of operation
// - Fetch, decode, inject descriptors by pointer
// - Each descriptor runs count plus one times
// - Size: bytes for accesses, cycles for delay
// - Delay descriptor issues no bus traffic
// - Common first word: irq, type, last
// - Descriptor irq enable raises interrupt
// - Last descriptor stops or restarts pattern
// - Access descriptors carry 32-bit start address
// - Error response accepted, injection continues unless the net event halts it
// - One compliant manager injection port
// - APB subordinate decoding 256-byte window
// - Single word accesses: config and feed
// - Software loads descriptors before starting
// - Soft reset wipes pattern, drains transfers
// - Hardware reset clears everything but the descriptor buffer
// - Flags: network, internal error, completion
// - Enabled network, internal and completion events (not feed overflow or descriptor irq) halt and set freeze when halt is enabled
// - Looping returns to first descriptor
// - Halt overrides looping
// - Readable, resettable counters and running
// - Config holds enables and halt enable
module ptinj_device
  import ptinj_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  ptinj_apb_if.sub apb,
  output logic [1:0] htrans_o,
  output logic [DATA_W-1:0] haddr_o,
  output logic hwrite_o,
  output logic [2:0] hsize_o,
  output logic [2:0] hburst_o,
  output logic [DATA_W-1:0] hwdata_o,
  input wire logic hready_i,
  input wire logic hresp_i,
  output logic running_o
);
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_FETCH0 = 6'b000010,
    S_FETCH1 = 6'b000100,
    S_ADDR = 6'b001000,
    S_DATA = 6'b010000,
    S_DELAY = 6'b100000
  } ptinj_state_t;

  function automatic logic [17:0] beats_of(input logic [D_SIZE_W-1:0] sz);
    logic [19:0] w;
    w = {1'b0, sz} + 20'h00003;
    beats_of = (w[19:2] == 18'h00000) ? 18'h00001 : w[19:2];
  endfunction

  logic [DATA_W-1:0] mem [BUF_DEPTH];
  ptinj_state_t st_q, st_d;
  logic [PTR_W-1:0] ptr_q, ptr_d, wcnt_q, wcnt_d;
  logic [DATA_W-1:0] d0_q, d0_d, base_q, base_d, addr_q, addr_d;
  logic [D_CNT_W-1:0] rep_q, rep_d;
  logic [17:0] beats_q, beats_d;
  logic [D_SIZE_W-1:0] dly_q, dly_d;
  logic [1:0] htrans_q, htrans_d;
  logic hwrite_q, hwrite_d;
  logic [DATA_W-1:0] hwdata_q, hwdata_d;
  logic [DATA_W-1:0] cfg_q, cfg_d, irq_cnt_q, irq_cnt_d, acc_cnt_q, acc_cnt_d;
  logic [DATA_W-1:0] prdata_q, prdata_d;
  logic [FLG_W-1:0] flg_q, flg_d, flg_set;
  logic srst_q, srst_d, pready_q, pready_d, perr_q, perr_d, irq_q;
  logic run_q;
  logic done, desc_evt, net_evt, core_evt, compl_evt, acc_evt, halt, clr_en;
  logic wr_acc, setup, feed_wr, feed_ok;
  logic [DATA_W-1:0] cur;
  logic [D_TYPE_W-1:0] ctype;

  assign cur = mem[ptr_q[PTR_W-2:0]];
  assign ctype = d0_q[D_TYPE_LSB +: D_TYPE_W];

  always_comb begin
    st_d = st_q;
    ptr_d = ptr_q;
    d0_d = d0_q;
    base_d = base_q;
    addr_d = addr_q;
    rep_d = rep_q;
    beats_d = beats_q;
    dly_d = dly_q;
    htrans_d = htrans_q;
    hwrite_d = hwrite_q;
    hwdata_d = hwdata_q;
    done = 1'b0;
    desc_evt = 1'b0;
    net_evt = 1'b0;
    core_evt = 1'b0;
    compl_evt = 1'b0;
    acc_evt = 1'b0;
    clr_en = 1'b0;
    case (st_q)
      S_IDLE: begin
        if (cfg_q[CFG_EN] && !srst_q && wcnt_q != 7'h00) begin
          ptr_d = 7'h00;
          st_d = S_FETCH0;
        end
      end
      S_FETCH0: begin
        if (!cfg_q[CFG_EN] || srst_q) begin
          st_d = S_IDLE;
        end else if (ptr_q >= wcnt_q) begin
          core_evt = 1'b1;
          clr_en = 1'b1;
          st_d = S_IDLE;
        end else begin
          d0_d = cur;
          ptr_d = ptr_q + 7'h01;
          rep_d = cur[D_CNT_LSB +: D_CNT_W];
          case (cur[D_TYPE_LSB +: D_TYPE_W])
            T_DELAY: begin
              dly_d = cur[D_SIZE_LSB +: D_SIZE_W];
              st_d = S_DELAY;
            end
            T_READ, T_WRITE, T_READ_FIX, T_WRITE_FIX: st_d = S_FETCH1;
            default: begin
              // Unsupported encoding stops the pattern
              core_evt = 1'b1;
              clr_en = 1'b1;
              st_d = S_IDLE;
            end
          endcase
        end
      end
      S_FETCH1: begin
        if (srst_q || ptr_q >= wcnt_q) begin
          core_evt = !srst_q;
          clr_en = 1'b1;
          st_d = S_IDLE;
        end else begin
          base_d = cur;
          addr_d = cur;
          ptr_d = ptr_q + 7'h01;
          beats_d = beats_of(d0_q[D_SIZE_LSB +: D_SIZE_W]);
          htrans_d = HTRANS_NONSEQ;
          hwrite_d = (ctype == T_WRITE) || (ctype == T_WRITE_FIX);
          hwdata_d = cur;
          st_d = S_ADDR;
        end
      end
      S_ADDR: begin
        if (hready_i) begin
          htrans_d = HTRANS_IDLE;
          st_d = S_DATA;
        end
      end
      S_DATA: begin
        if (hready_i) begin
          acc_evt = 1'b1;
          net_evt = hresp_i;
          // soft reset acts once the beat ends
          if (srst_q) begin
            st_d = S_IDLE;
          end else if (beats_q > 18'h00001) begin
            beats_d = beats_q - 18'h00001;
            if (ctype != T_READ_FIX && ctype != T_WRITE_FIX) begin
              addr_d = addr_q + WORD_STEP;
            end
            hwdata_d = hwdata_q + 32'h00000001;
            htrans_d = HTRANS_NONSEQ;
            st_d = S_ADDR;
          end else begin
            done = 1'b1;
          end
        end
      end
      S_DELAY: begin
        // idle bus for the programmed cycles
        if (srst_q) begin
          st_d = S_IDLE;
        end else if (dly_q <= 19'h00001) begin
          done = 1'b1;
        end else begin
          dly_d = dly_q - 19'h00001;
        end
      end
      default: st_d = S_IDLE;
    endcase
    if (done) begin
      if (rep_q != 6'h00) begin
        rep_d = rep_q - 6'h01;
        if (ctype == T_DELAY) begin
          dly_d = d0_q[D_SIZE_LSB +: D_SIZE_W];
          st_d = S_DELAY;
        end else begin
          addr_d = base_q;
          beats_d = beats_of(d0_q[D_SIZE_LSB +: D_SIZE_W]);
          htrans_d = HTRANS_NONSEQ;
          st_d = S_ADDR;
        end
      end else begin
        desc_evt = d0_q[D_IRQ];
        st_d = S_FETCH0;
        if (d0_q[D_LAST]) begin
          compl_evt = 1'b1;
          if (cfg_q[CFG_QUEUE]) begin
            ptr_d = 7'h00;
          end else begin
            clr_en = 1'b1;
            st_d = S_IDLE;
          end
        end
      end
    end
    halt = cfg_q[CFG_FREEZE_EN] &&
           ((net_evt && cfg_q[CFG_IE_NET]) ||
            (core_evt && cfg_q[CFG_IE_CORE]) ||
            (compl_evt && cfg_q[CFG_IE_COMPL]));
    if (halt) begin
      clr_en = 1'b1;
      htrans_d = HTRANS_IDLE;
      st_d = S_IDLE;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q <= S_IDLE;
      ptr_q <= 7'h00;
      d0_q <= 32'h00000000;
      base_q <= 32'h00000000;
      addr_q <= 32'h00000000;
      rep_q <= 6'h00;
      beats_q <= 18'h00000;
      dly_q <= 19'h00000;
      htrans_q <= HTRANS_IDLE;
      hwrite_q <= 1'b0;
      hwdata_q <= 32'h00000000;
      run_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ptr_q <= ptr_d;
      d0_q <= d0_d;
      base_q <= base_d;
      addr_q <= addr_d;
      rep_q <= rep_d;
      beats_q <= beats_d;
      dly_q <= dly_d;
      htrans_q <= htrans_d;
      hwrite_q <= hwrite_d;
      hwdata_q <= hwdata_d;
      run_q <= st_d != S_IDLE;
    end
  end

  // zero-wait subordinate, ready registered from the setup phase
  assign setup = apb.psel && !apb.penable && !pready_q;
  assign wr_acc = apb.psel && apb.penable && pready_q && apb.pwrite;
  assign feed_wr = wr_acc && apb.paddr == OFS_FEED;
  assign feed_ok = wcnt_q < BUF_DEPTH_P;

  always_comb begin
    cfg_d = cfg_q;
    wcnt_d = wcnt_q;
    irq_cnt_d = irq_cnt_q;
    acc_cnt_d = acc_cnt_q;
    srst_d = srst_q && st_q != S_IDLE;
    pready_d = setup;
    prdata_d = 32'h00000000;
    perr_d = 1'b0;
    flg_set = {halt, compl_evt && cfg_q[CFG_IE_COMPL],
               (core_evt && cfg_q[CFG_IE_CORE]) || 1'b0,
               net_evt && cfg_q[CFG_IE_NET], desc_evt};
    // overflowing feed write is an internal error
    if (feed_wr && !feed_ok) begin
      flg_set[FLG_CORE] = cfg_q[CFG_IE_CORE];
    end
    // sticky flags, set wins over write-one clear
    flg_d = flg_q | flg_set;
    if (wr_acc && apb.paddr == OFS_CFG) begin
      flg_d = (flg_q & ~apb.pwdata[FLG_LSB +: FLG_W]) | flg_set;
    end
    if (flg_set != 5'h00) begin
      irq_cnt_d = irq_cnt_q + 32'h00000001;
    end
    if (acc_evt) begin
      acc_cnt_d = acc_cnt_q + 32'h00000001;
    end
    if (setup) begin
      case (apb.paddr)
        OFS_CFG: prdata_d = cfg_q | ({31'h0, st_q != S_IDLE} << CFG_RUN) |
                            ({27'h0, flg_q} << FLG_LSB);
        OFS_IRQ_CNT: prdata_d = irq_cnt_q;
        OFS_ACC_CNT: prdata_d = acc_cnt_q;
        OFS_FEED: prdata_d = 32'h00000000;
        default: perr_d = 1'b1;
      endcase
    end
    if (wr_acc) begin
      case (apb.paddr)
        OFS_CFG: cfg_d = apb.pwdata & CFG_RW_MASK;
        OFS_IRQ_CNT, OFS_ACC_CNT: begin
          irq_cnt_d = 32'h00000000;
          acc_cnt_d = 32'h00000000;
        end
        OFS_FEED: begin
          if (feed_ok) begin
            wcnt_d = wcnt_q + 7'h01;
          end
        end
        default: cfg_d = cfg_q;
      endcase
    end
    if (clr_en) begin
      cfg_d[CFG_EN] = 1'b0;
    end
    // soft reset wipes pattern and settings
    if (wr_acc && apb.paddr == OFS_CFG && apb.pwdata[CFG_SRST]) begin
      cfg_d = CFG_RESET;
      wcnt_d = 7'h00;
      flg_d = 5'h00;
      irq_cnt_d = 32'h00000000;
      acc_cnt_d = 32'h00000000;
      srst_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_q <= CFG_RESET;
      wcnt_q <= 7'h00;
      irq_cnt_q <= 32'h00000000;
      acc_cnt_q <= 32'h00000000;
      flg_q <= 5'h00;
      srst_q <= 1'b0;
      pready_q <= 1'b0;
      prdata_q <= 32'h00000000;
      perr_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      wcnt_q <= wcnt_d;
      irq_cnt_q <= irq_cnt_d;
      acc_cnt_q <= acc_cnt_d;
      flg_q <= flg_d;
      srst_q <= srst_d;
      pready_q <= pready_d;
      prdata_q <= prdata_d;
      perr_q <= perr_d;
      irq_q <= flg_d != 5'h00;
    end
  end

  // Buffer has no reset: the word count alone decides what is valid
  always_ff @(posedge clk_i) begin
    if (feed_wr && feed_ok) begin
      mem[wcnt_q[PTR_W-2:0]] <= apb.pwdata;
    end
  end

  assign apb.prdata = prdata_q;
  assign apb.pready = pready_q;
  assign apb.pslverr = perr_q;
  assign apb.irq = irq_q;
  assign htrans_o = htrans_q;
  assign haddr_o = addr_q;
  assign hwrite_o = hwrite_q;
  assign hsize_o = HSIZE_WORD;
  assign hburst_o = HBURST_SINGLE;
  assign hwdata_o = hwdata_q;
  assign running_o = run_q;
endmodule

// file: inc/ptinj_pkg.sv
package ptinj_pkg;
  // Programming window and descriptor buffer
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int BUF_DEPTH = 64;
  localparam int PTR_W = 7;
  localparam logic [PTR_W-1:0] BUF_DEPTH_P = 7'h40;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_CFG = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CNT = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_ACC_CNT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_FEED = 8'hFC;

  // Configuration register fields
  localparam int CFG_EN = 0;
  localparam int CFG_SRST = 1;
  localparam int CFG_QUEUE = 2;
  localparam int CFG_IE_COMPL = 3;
  localparam int CFG_IE_CORE = 4;
  localparam int CFG_IE_NET = 5;
  localparam int CFG_FREEZE_EN = 6;
  localparam int CFG_RUN = 8;
  localparam int FLG_LSB = 16;
  localparam int FLG_W = 5;
  localparam int FLG_DESC = 0;
  localparam int FLG_NET = 1;
  localparam int FLG_CORE = 2;
  localparam int FLG_COMPL = 3;
  localparam int FLG_FREEZE = 4;
  localparam logic [DATA_W-1:0] CFG_RW_MASK = 32'h0000007D;
  localparam logic [DATA_W-1:0] CFG_RESET = 32'h00000000;

  // First descriptor word layout
  localparam int D_TYPE_LSB = 0;
  localparam int D_TYPE_W = 5;
  localparam int D_LAST = 5;
  localparam int D_IRQ = 6;
  localparam int D_CNT_LSB = 7;
  localparam int D_CNT_W = 6;
  localparam int D_SIZE_LSB = 13;
  localparam int D_SIZE_W = 19;

  localparam logic [D_TYPE_W-1:0] T_READ = 5'h00;
  localparam logic [D_TYPE_W-1:0] T_WRITE = 5'h01;
  localparam logic [D_TYPE_W-1:0] T_DELAY = 5'h02;
  localparam logic [D_TYPE_W-1:0] T_READ_FIX = 5'h03;
  localparam logic [D_TYPE_W-1:0] T_WRITE_FIX = 5'h04;

  // Injection port encodings
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [2:0] HBURST_SINGLE = 3'h0;
  localparam logic [DATA_W-1:0] WORD_STEP = 32'h00000004;
endpackage

// file: inc/ptinj_apb_if.sv
interface ptinj_apb_if;
  import ptinj_pkg::*;
  logic psel;
  logic penable;
  logic pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;

  modport mgr (output psel, penable, pwrite, paddr, pwdata,
               input prdata, pready, pslverr, irq);
  modport sub (input psel, penable, pwrite, paddr, pwdata,
               output prdata, pready, pslverr, irq);
endinterface

// file: src/ptinj_host.sv
// APB manager end: one register access per request.
module ptinj_host
  import ptinj_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  ptinj_apb_if.mgr apb,
  input wire logic req_i,
  input wire logic req_write_i,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic [DATA_W-1:0] req_wdata_i,
  output logic ack_o,
  output logic [DATA_W-1:0] rdata_o,
  output logic err_o,
  output logic busy_o,
  output logic irq_o
);
  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_SETUP = 3'b010,
    H_ACCESS = 3'b100
  } ptinj_hstate_t;

  ptinj_hstate_t st_q, st_d;
  logic psel_q, psel_d, pen_q, pen_d, pwr_q, pwr_d;
  logic [ADDR_W-1:0] paddr_q, paddr_d;
  logic [DATA_W-1:0] pwdata_q, pwdata_d, rdata_q, rdata_d;
  logic ack_q, ack_d, err_q, err_d, irq_q;

  always_comb begin
    st_d = st_q;
    psel_d = psel_q;
    pen_d = pen_q;
    pwr_d = pwr_q;
    paddr_d = paddr_q;
    pwdata_d = pwdata_q;
    rdata_d = rdata_q;
    err_d = err_q;
    ack_d = 1'b0;
    case (st_q)
      H_IDLE: begin
        if (req_i) begin
          psel_d = 1'b1;
          pwr_d = req_write_i;
          paddr_d = {req_addr_i[ADDR_W-1:2], 2'h0};
          pwdata_d = req_wdata_i;
          st_d = H_SETUP;
        end
      end
      H_SETUP: begin
        pen_d = 1'b1;
        st_d = H_ACCESS;
      end
      H_ACCESS: begin
        if (apb.pready) begin
          psel_d = 1'b0;
          pen_d = 1'b0;
          ack_d = 1'b1;
          err_d = apb.pslverr;
          rdata_d = apb.prdata;
          st_d = H_IDLE;
        end
      end
      default: begin
        st_d = H_IDLE;
        psel_d = 1'b0;
        pen_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q <= H_IDLE;
      psel_q <= 1'b0;
      pen_q <= 1'b0;
      pwr_q <= 1'b0;
      paddr_q <= 8'h00;
      pwdata_q <= 32'h00000000;
      rdata_q <= 32'h00000000;
      err_q <= 1'b0;
      ack_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      st_q <= st_d;
      psel_q <= psel_d;
      pen_q <= pen_d;
      pwr_q <= pwr_d;
      paddr_q <= paddr_d;
      pwdata_q <= pwdata_d;
      rdata_q <= rdata_d;
      err_q <= err_d;
      ack_q <= ack_d;
      irq_q <= apb.irq;
    end
  end

  assign apb.psel = psel_q;
  assign apb.penable = pen_q;
  assign apb.pwrite = pwr_q;
  assign apb.paddr = paddr_q;
  assign apb.pwdata = pwdata_q;
  assign ack_o = ack_q;
  assign rdata_o = rdata_q;
  assign err_o = err_q;
  assign busy_o = psel_q;
  assign irq_o = irq_q;
endmodule

// file: bench/ptinj_props.sv
module ptinj_props
  import ptinj_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  logic mapped;
  logic acc;
  assign mapped = paddr inside {OFS_CFG, OFS_IRQ_CNT, OFS_ACC_CNT, OFS_FEED};
  assign acc = psel && penable && pready;
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable && pready;
  endsequence
  sequence idle_s;
    !psel && !penable;
  endsequence
  a_apb_phases: assert property ($rose(psel) |->
    setup_s ##1 access_s ##1 idle_s)
    else $error("transfer phases out of order");
  a_addr_stable: assert property (psel && penable |->
    $stable(paddr) && $stable(pwrite) && $stable(pwdata))
    else $error("request changed during access");
  a_enable_sel: assert property (penable |-> psel)
    else $error("enable without select");
  a_unmapped_err: assert property (acc && !mapped |-> pslverr)
    else $error("unmapped offset not refused");
  a_mapped_ok: assert property (acc && mapped |-> !pslverr)
    else $error("mapped offset refused");
  a_word_align: assert property (psel |-> paddr[1:0] == 2'h0)
    else $error("request not word aligned");
  a_feed_zero: assert property (acc && !pwrite &&
    paddr == OFS_FEED |-> prdata == 32'h00000000)
    else $error("feed read not zero");
  a_srst_irq_low: assert property (acc && pwrite &&
    paddr == OFS_CFG && pwdata[CFG_SRST] |-> ##[1:3] !irq)
    else $error("irq kept after soft reset");
  a_sel_two: assert property ($rose(psel) |-> psel [*2] ##1 !psel)
    else $error("select length wrong");
endmodule

// file: bench/tb.sv
module tb import ptinj_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] B_EN = 32'h00000001 << CFG_EN;
  localparam logic [31:0] B_SR = 32'h00000001 << CFG_SRST;
  localparam logic [31:0] B_Q = 32'h00000001 << CFG_QUEUE;
  localparam logic [31:0] B_IC = 32'h00000001 << CFG_IE_COMPL;
  localparam logic [31:0] B_IE = 32'h00000001 << CFG_IE_CORE;
  localparam logic [31:0] B_IN = 32'h00000001 << CFG_IE_NET;
  localparam logic [31:0] B_FZ = 32'h00000001 << CFG_FREEZE_EN;
  localparam logic [31:0] F_DS = 32'h00000001 << (FLG_LSB + FLG_DESC);
  localparam logic [31:0] F_NT = 32'h00000001 << (FLG_LSB + FLG_NET);
  localparam logic [31:0] F_CR = 32'h00000001 << (FLG_LSB + FLG_CORE);
  localparam logic [31:0] F_CP = 32'h00000001 << (FLG_LSB + FLG_COMPL);
  localparam logic [31:0] F_FZ = 32'h00000001 << (FLG_LSB + FLG_FREEZE);
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic req = 1'b0;
  logic req_w = 1'b0;
  logic [ADDR_W-1:0] req_a = 8'h00;
  logic [DATA_W-1:0] req_d = 32'h00000000;
  logic hready = 1'b1;
  logic hresp = 1'b0;
  logic stall = 1'b0;
  logic nerr = 1'b0;
  logic [1:0] cyc = 2'h0;
  logic ack, err, busy, irq_h, hwrite, run;
  logic [DATA_W-1:0] rdata, haddr, hwdata;
  logic [1:0] htrans;
  logic [2:0] hsize, hburst;
  logic [64:0] bq[$];
  int miscompares = 0;
  int compares = 0;
  ptinj_apb_if apb_if();
  ptinj_host ptinj_host_i (.clk_i(clk), .rstn_i(rstn), .apb(apb_if),
    .req_i(req), .req_write_i(req_w), .req_addr_i(req_a),
    .req_wdata_i(req_d), .ack_o(ack), .rdata_o(rdata), .err_o(err),
    .busy_o(busy), .irq_o(irq_h));
  ptinj_device ptinj_device_i (.clk_i(clk), .rstn_i(rstn), .apb(apb_if),
    .htrans_o(htrans), .haddr_o(haddr), .hwrite_o(hwrite), .hsize_o(hsize),
    .hburst_o(hburst), .hwdata_o(hwdata), .hready_i(hready),
    .hresp_i(hresp), .running_o(run));
  ptinj_props ptinj_props_i (.clk_i(clk), .rstn_i(rstn),
    .psel(apb_if.psel), .penable(apb_if.penable), .pwrite(apb_if.pwrite),
    .paddr(apb_if.paddr), .pwdata(apb_if.pwdata), .prdata(apb_if.prdata),
    .pready(apb_if.pready), .pslverr(apb_if.pslverr), .irq(apb_if.irq));
  always #5 clk = ~clk;
  // Interconnect stand-in: ready only one cycle in four when asked
  always @(posedge clk) begin
    cyc <= cyc + 2'h1;
    hready <= !stall || cyc == 2'h0;
    hresp <= nerr;
    if (htrans === HTRANS_NONSEQ && hready === 1'b1)
      bq.push_back({hwrite, haddr, hwdata});
  end
  task automatic close_out();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic fail(string s);
    $display("unexpected %s: expected done, seen timeout", s);
    miscompares++;
    close_out();
  endtask
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      $display("unexpected %s: expected %h, seen %h", s, e, g);
      miscompares++;
    end
  endtask
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge clk);
    req_w <= w;
    req_a <= a;
    req_d <= d;
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) fail("bus ack");
    r = rdata;
    e = err;
    chk("busy after ack", 32'h00000000, {31'h0, busy});
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] r;
    logic e;
    bus(1'b1, a, d, r, e);
    chk("write error", 32'h00000000, {31'h0, e});
  endtask
  task automatic rd(logic [7:0] a, output logic [31:0] r);
    logic e;
    bus(1'b0, a, 32'h00000000, r, e);
  endtask
  task automatic wait_run(logic v, int lim);
    int n;
    n = 0;
    while (run !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (n >= lim) fail("running level");
  endtask
  task automatic wait_beats(int k, int lim, inout int n);
    while (bq.size() < k && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (bq.size() < k) fail("beat count");
  endtask
  function automatic logic [31:0] w0(logic [4:0] t, logic l, logic q,
                                     logic [5:0] c, logic [18:0] s);
    return {s, c, q, l, t};
  endfunction
  task automatic srst();
    logic [31:0] r;
    wr(OFS_CFG, B_SR);
    wait_run(1'b0, 100);
    rd(OFS_CFG, r);
    chk("cfg after soft reset", CFG_RESET, r);
    bq.delete();
  endtask
  task automatic s_regs();
    logic [31:0] r;
    logic e;
    rd(OFS_CFG, r);
    chk("cfg reset", CFG_RESET, r);
    rd(OFS_IRQ_CNT, r);
    chk("irq count reset", 32'h00000000, r);
    bus(1'b1, 8'h10, 32'hFFFFFFFF, r, e);
    chk("unmapped error", 32'h00000001, {31'h0, e});
    rd(OFS_FEED, r);
    chk("feed read", 32'h00000000, r);
    wr(OFS_CFG, 32'hFFFFFFFC);
    rd(OFS_CFG, r);
    chk("cfg read back", CFG_RW_MASK & 32'hFFFFFFFC, r);
    chk("size", {29'h0, HSIZE_WORD}, {29'h0, hsize});
    chk("burst", {29'h0, HBURST_SINGLE}, {29'h0, hburst});
    srst();
  endtask
  task automatic s_read();
    logic [31:0] r;
    wr(OFS_FEED, w0(T_READ, 1'b1, 1'b1, 6'h01, 19'h00008));
    wr(OFS_FEED, 32'h00001000);
    stall <= 1'b1;
    wr(OFS_CFG, B_EN | B_IC);
    wait_run(1'b1, 8);
    wait_run(1'b0, 400);
    stall <= 1'b0;
    chk("read beats", 32'h00000004, bq.size());
    foreach (bq[i])
      chk("read addr", 32'h1000 + 32'h4 * (i % 2), bq[i][63:32]);
    rd(OFS_CFG, r);
    chk("read flags", B_IC | F_DS | F_CP, r);
    chk("irq", 32'h00000001, {31'h0, irq_h});
    rd(OFS_ACC_CNT, r);
    chk("access count", 32'h00000004, r);
    rd(OFS_IRQ_CNT, r);
    chk("irq count", 32'h00000001, r);
    wr(OFS_IRQ_CNT, 32'h00000000);
    rd(OFS_ACC_CNT, r);
    chk("access count clear", 32'h00000000, r);
    wr(OFS_CFG, B_IC | F_DS | F_CP);
    rd(OFS_CFG, r);
    chk("flags clear", B_IC, r);
    srst();
  endtask
  task automatic s_werr();
    logic [31:0] r;
    for (int h = 0; h < 2; h++) begin
      wr(OFS_FEED, w0(T_WRITE_FIX, 1'b1, 1'b0, 6'h02, 19'h00004));
      wr(OFS_FEED, 32'h00002000);
      nerr <= 1'b1;
      wr(OFS_CFG, B_EN | B_IN | (h == 1 ? B_FZ : 32'h00000000));
      wait_run(1'b1, 8);
      wait_run(1'b0, 400);
      nerr <= 1'b0;
      rd(OFS_CFG, r);
      if (h == 0) begin
        chk("error beats", 32'h00000003, bq.size());
        chk("net flag", B_IN | F_NT, r);
      end else begin
        chk("halt early", 32'h00000001, {31'h0, bq.size() < 3});
        chk("halt flags", B_IN | B_FZ | F_NT | F_FZ, r);
      end
      chk("write dir", 32'h00000001, {31'h0, bq[0][64]});
      chk("write addr", 32'h00002000, bq[0][63:32]);
      chk("write data", 32'h00002000, bq[0][31:0]);
      srst();
    end
  endtask
  task automatic s_loop();
    int n;
    logic [31:0] r;
    wr(OFS_FEED, w0(T_DELAY, 1'b0, 1'b0, 6'h00, 19'h00018));
    wr(OFS_FEED, w0(T_READ, 1'b1, 1'b0, 6'h00, 19'h00004));
    wr(OFS_FEED, 32'h00003000);
    wr(OFS_CFG, B_EN | B_Q);
    n = 0;
    wait_beats(1, 200, n);
    // Enable lands on the same edge as ack, so allow one cycle slack
    chk("delay quiet", 32'h00000001, {31'h0, n >= 23});
    wait_beats(3, 600, n);
    chk("loop beats", 32'h00000003, bq.size());
    wr(OFS_CFG, B_EN | B_Q | B_IC | B_FZ);
    wait_run(1'b0, 200);
    rd(OFS_CFG, r);
    chk("halt over loop", B_Q | B_IC | B_FZ | F_CP | F_FZ, r);
    srst();
  endtask
  task automatic s_core();
    logic [31:0] r;
    wr(OFS_CFG, B_IE);
    for (int i = 0; i <= BUF_DEPTH; i++) wr(OFS_FEED, 32'h00000002);
    rd(OFS_CFG, r);
    chk("overflow flag", B_IE | F_CR, r);
    srst();
    wr(OFS_FEED, w0(5'h1F, 1'b1, 1'b0, 6'h00, 19'h00004));
    wr(OFS_CFG, B_EN | B_IE);
    wait_run(1'b1, 8);
    wait_run(1'b0, 50);
    rd(OFS_CFG, r);
    chk("bad type", B_IE | F_CR, r);
    chk("bad type beats", 32'h00000000, bq.size());
    srst();
  endtask
  task automatic s_reset();
    int n;
    logic [31:0] r;
    for (int h = 0; h < 2; h++) begin
      wr(OFS_FEED, w0(T_READ, 1'b1, 1'b0, 6'h00, 19'h00004));
      wr(OFS_FEED, 32'h00004000);
      stall <= 1'b1;
      wr(OFS_CFG, B_EN | B_Q);
      n = 0;
      wait_beats(1, 100, n);
      stall <= 1'b0;
      if (h == 0) begin
        srst();
        wr(OFS_CFG, B_EN);
        // Quiet spell: a surviving pattern would start within it
        repeat (30) @(negedge clk);
        chk("pattern wiped", 32'h00000000, bq.size());
        rd(OFS_CFG, r);
        chk("idle enable kept", B_EN, r);
        wr(OFS_CFG, 32'h00000000);
      end else begin
        @(posedge clk);
        rstn <= 1'b0;
        @(negedge clk);
        chk("reset idle", {30'h0, HTRANS_IDLE}, {30'h0, htrans});
        @(posedge clk);
        rstn <= 1'b1;
      end
      rd(OFS_CFG, r);
      chk("cfg after reset", CFG_RESET, r);
      bq.delete();
    end
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    s_regs();
    s_read();
    s_werr();
    s_loop();
    s_core();
    s_reset();
    close_out();
  end
endmodule
